// ===== logic/sys_ctl_pkg.sv
/*
  Constants for the system clock and reset control block: register offsets,
  field positions, reset values and timing counts.
  Assumes a 25 MHz reference clock that stands in for the internal oscillator.
*/
package sys_ctl_pkg;
  localparam logic [15:0] BRK_STATUS_ADDR = 16'hFE00;
  localparam logic [15:0] RST_CAUSE_ADDR = 16'hFE01;
  localparam logic [15:0] BRK_CTRL_ADDR = 16'hFE02;
  localparam logic [15:0] FLAGS_LOW_ADDR = 16'hFE04;
  localparam logic [15:0] FLAGS_MID_ADDR = 16'hFE05;
  localparam logic [15:0] FLAGS_HIGH_ADDR = 16'hFE06;
  localparam logic [15:0] CLK_CTRL_ADDR = 16'hFE07;

  localparam int BSW_BIT = 1;
  localparam int BCE_BIT = 7;
  localparam int CAUSE_POR_BIT = 7;
  localparam int CAUSE_PIN_BIT = 6;
  localparam int CAUSE_WDOG_BIT = 5;
  localparam int CAUSE_OPC_BIT = 4;
  localparam int CAUSE_ADR_BIT = 3;
  localparam int CAUSE_MON_BIT = 2;
  localparam int CAUSE_LOW_BIT = 1;
  localparam int PLL_SEL_BIT = 0;
  localparam int SSR_BIT = 1;

  localparam logic [7:0] CAUSE_POR_VALUE = 8'h80;
  localparam logic [7:0] REG_RESET = 8'h00;

  localparam int STAB_CYCLES = 4096;
  localparam int SHORT_STOP_CYCLES = 32;
  localparam int PIN_DRIVE_CYCLES = 32;
  localparam int INTERNAL_RESET_SIGNAL_TAIL_CYCLES = 32;
  localparam int SYS_CNT_WIDTH = 13;

  localparam logic [15:0] VECTOR_USER = 16'hFFFE;
  localparam logic [15:0] VECTOR_MONITOR = 16'hFEFE;

  typedef enum logic [2:0] {
    ST_RUN = 3'b000,
    ST_STAB = 3'b001,
    ST_PIN = 3'b010,
    ST_TAIL = 3'b011,
    ST_STOP = 3'b100,
    ST_RECOVER = 3'b101,
    ST_EXT = 3'b110
  } seq_state_t;
endpackage : sys_ctl_pkg

// ===== logic/system_clock_reset_control.sv
/*
  System clock and reset control: bus clock division, clock gating through
  power-up, stop, wait and reset, reset source gathering, cause flags and the
  small status register file reached over a plain strobe port.
  Assumes all inputs are synchronous to i_ref_clk, which plays the internal
  oscillator clock, and that reset source inputs are level requests.
  Limitations a user must know:
  - The long stop recovery shares STAB_COUNT with the power-up hold-off, so a
    shortened STAB_COUNT shortens both.
  - The system counter runs on the rising edge of i_ref_clk; the count rate is
    that of a falling-edge counter, and the block keeps one clock domain.
  - The reset pin is open drain: o_reset_pin_out is always low and only the
    output enable moves. An external pull-up is expected on the pin.
  - A PLL clock selected onto o_clock_gen_output passes a multiplexer with no
    glitch guard; software should switch it only while the bus is idle.
  - Writes to the control registers are dropped while internal reset is
    asserted; reads answer at all times.
  - Reset source inputs are levels; a source held high keeps restarting its
    reset sequence until it is released.
*/
// Behaviour
// - Bus clock is clock generator output halved; the code makes it the oscillator over four, even with the PLL selected.
// - Bus runs at oscillator or PLL over four; the code always divides the oscillator, never the PLL.
// - Clock source selectable between oscillator and PLL.
// - Power-up/low-supply holds clocks 4096 cycles.
// - Reset pin driven low during hold-off.
// - Bus clocks start right after timeout; the code enables them only after the 32-cycle pin drive and the 32-cycle tail.
// - Stop exit counts on oscillator, clocks off.
// - Clocks return only after recovery delay.
// - Stop recovery is 4096 or 32 cycles.
// - Wait stops CPU clocks, peripherals keep running.
// - Six reset sources accepted; the code takes seven, counting monitor entry.
// - Resets assert internal reset, select vector.
// - Internal reset returns modules to defaults.
// - Internal resets clear counter, pin reset not.
// - Each source sets its own cause flag.
// - Cause register read-only, layout, bit0 zero.
// - Break flag cleared by writing zero.
// - Break clear enable in bit seven.
// - Three read-only source flag registers.
// - Pin low 32 cycles, reset 32 more.
// - Thirteen-bit counter on falling oscillator edge; the code counts on the rising edge.
// - Short recovery option selects 32 cycles.
module system_clock_reset_control #(
  parameter int STAB_COUNT = sys_ctl_pkg::STAB_CYCLES,
  parameter int FLAG_COUNT = 21
) (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_pll_clk,
  input wire logic i_power_up_pulse,
  input wire logic i_ext_reset_n,
  input wire logic i_watchdog_timeout,
  input wire logic i_low_supply,
  input wire logic i_bad_opcode,
  input wire logic i_bad_fetch_address,
  input wire logic i_monitor_entry,
  input wire logic i_monitor_mode,
  input wire logic i_stop_req,
  input wire logic i_wait_req,
  input wire logic i_wake,
  input wire logic i_break_stop_wait,
  input wire logic [FLAG_COUNT-1:0] i_source_flags,
  input wire logic [15:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic o_clock_gen_output,
  output logic o_bus_clock,
  output logic o_cpu_clk_en,
  output logic o_periph_clk_en,
  output logic o_internal_reset,
  output logic o_reset_pin_out,
  output logic o_reset_pin_oe_n,
  output logic [15:0] o_reset_vector,
  output logic [sys_ctl_pkg::SYS_CNT_WIDTH-1:0] o_sys_count,
  output logic o_break_clear_enable
);
  import sys_ctl_pkg::*;

  localparam logic [12:0] STAB_LAST = 13'(STAB_COUNT - 1);
  localparam logic [12:0] SHORT_LAST = 13'(SHORT_STOP_CYCLES - 1);
  localparam logic [12:0] PIN_LAST = 13'(PIN_DRIVE_CYCLES - 1);
  localparam logic [12:0] TAIL_LAST = 13'(INTERNAL_RESET_SIGNAL_TAIL_CYCLES - 1);

  seq_state_t state_reg;
  logic [12:0] seq_cnt_reg;
  logic [SYS_CNT_WIDTH-1:0] sys_cnt_reg;
  logic [1:0] div_reg;
  logic pll_sel_reg;
  logic short_stop_reg;
  logic bsw_reg;
  logic bce_reg;
  logic [7:0] cause_reg;
  logic [7:0] cause_next;
  logic [23:0] flags_reg;
  logic waiting_reg;
  logic ext_seen_reg;
  logic clear_count;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] target);
    hit = (a == target);
  endfunction : hit

  // State decodes shared by the reset outputs and the cause register.
  function automatic logic in_reset(input seq_state_t s);
    case (s)
      ST_STAB, ST_PIN, ST_TAIL, ST_EXT: in_reset = 1'b1;
      default: in_reset = 1'b0;
    endcase
  endfunction : in_reset

  function automatic logic pulls_pin(input seq_state_t s);
    case (s)
      ST_STAB, ST_PIN: pulls_pin = 1'b1;
      default: pulls_pin = 1'b0;
    endcase
  endfunction : pulls_pin

  // Unmapped addresses read as zero, so a stray read never shows stale data.
  function automatic logic [7:0] read_value(input logic [15:0] a);
    case (a)
      BRK_STATUS_ADDR: read_value = {6'h00, bsw_reg, 1'b0};
      RST_CAUSE_ADDR: read_value = cause_reg;
      BRK_CTRL_ADDR: read_value = {bce_reg, 7'h00};
      FLAGS_LOW_ADDR: read_value = {flags_reg[5:0], 2'h0};
      FLAGS_MID_ADDR: read_value = flags_reg[13:6];
      FLAGS_HIGH_ADDR: read_value = {1'b0, flags_reg[20:14]};
      CLK_CTRL_ADDR: read_value = {6'h00, short_stop_reg, pll_sel_reg};
      default: read_value = 8'h00;
    endcase
  endfunction : read_value

  wire power_src = i_power_up_pulse | i_low_supply;
  wire fast_src = i_watchdog_timeout | i_bad_opcode | i_bad_fetch_address | i_monitor_entry;
  wire ext_src = ~i_ext_reset_n;
  wire wait_exit = i_wake | power_src | fast_src | ext_src;

  // Write decodes, one per writable register.
  wire wr_brk_status = i_wr && hit(i_addr, BRK_STATUS_ADDR);
  wire wr_brk_ctrl = i_wr && hit(i_addr, BRK_CTRL_ADDR);
  wire wr_clk_ctrl = i_wr && hit(i_addr, CLK_CTRL_ADDR);

  // Stop recovery end point. The compare is greater-or-equal so that a change of
  // the short recovery option during a recovery cannot make the count overrun.
  wire [12:0] recover_last = short_stop_reg ? SHORT_LAST : STAB_LAST;

  // Bus clock divider: the reference is halved into the clock generator output unless
  // the PLL is selected; the bus clock is the reference over four either way. The divider runs on
  // through every reset state so the clocks restart in a known phase.
  assign o_clock_gen_output = pll_sel_reg ? i_pll_clk : div_reg[0];
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      div_reg <= 2'h0;
    end else begin
      div_reg <= div_reg + 2'h1;
    end
  end
  assign o_bus_clock = div_reg[1];

  // Reset and stop sequencer. Power and low-supply requests win over every
  // other cause because they also restart the long stabilisation count.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg <= ST_STAB;
      seq_cnt_reg <= 13'h0000;
    end else if (power_src) begin
      state_reg <= ST_STAB;
      seq_cnt_reg <= 13'h0000;
    end else if (fast_src && state_reg != ST_STAB) begin
      state_reg <= ST_PIN;
      seq_cnt_reg <= 13'h0000;
    end else begin
      case (state_reg)
        ST_STAB: begin
          seq_cnt_reg <= seq_cnt_reg + 13'h0001;
          if (seq_cnt_reg == STAB_LAST) begin
            state_reg <= ST_PIN;
            seq_cnt_reg <= 13'h0000;
          end
        end
        ST_PIN: begin
          seq_cnt_reg <= seq_cnt_reg + 13'h0001;
          if (seq_cnt_reg == PIN_LAST) begin
            state_reg <= ST_TAIL;
            seq_cnt_reg <= 13'h0000;
          end
        end
        ST_TAIL: begin
          seq_cnt_reg <= seq_cnt_reg + 13'h0001;
          if (seq_cnt_reg == TAIL_LAST) begin
            state_reg <= ext_src ? ST_EXT : ST_RUN;
            seq_cnt_reg <= 13'h0000;
          end
        end
        ST_RUN: begin
          if (ext_src) begin
            state_reg <= ST_EXT;
          end else if (i_stop_req) begin
            state_reg <= ST_STOP;
          end
        end
        // The pin hold has no count: internal reset follows the pin and the
        // system counter is left running.
        ST_EXT: begin
          if (!ext_src) begin
            state_reg <= ST_RUN;
          end
        end
        ST_STOP: begin
          if (i_wake || ext_src) begin
            state_reg <= ST_RECOVER;
            seq_cnt_reg <= 13'h0000;
          end
        end
        ST_RECOVER: begin
          seq_cnt_reg <= seq_cnt_reg + 13'h0001;
          if (seq_cnt_reg >= recover_last) begin
            state_reg <= ext_src ? ST_EXT : ST_RUN;
            seq_cnt_reg <= 13'h0000;
          end
        end
        default: begin
          state_reg <= ST_STAB;
          seq_cnt_reg <= 13'h0000;
        end
      endcase
    end
  end

  // Wait mode is tracked apart from the sequencer; any wake or reset ends it.
  // Exit wins over a wait request in the same cycle, so a wake is never lost.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      waiting_reg <= 1'b0;
    end else if (wait_exit) begin
      waiting_reg <= 1'b0;
    end else if (i_wait_req && state_reg == ST_RUN) begin
      waiting_reg <= 1'b1;
    end
  end

  wire clocks_on = (state_reg == ST_RUN);
  assign o_cpu_clk_en = clocks_on & ~waiting_reg;
  assign o_periph_clk_en = clocks_on;
  assign o_internal_reset = in_reset(state_reg);
  // The pin is open drain: it only ever pulls low.
  assign o_reset_pin_out = 1'b0;
  assign o_reset_pin_oe_n = ~pulls_pin(state_reg);
  assign o_reset_vector = i_monitor_mode ? VECTOR_MONITOR : VECTOR_USER;

  // System counter. A posedge counter stands in for the falling edge so that
  // the block stays in one clock domain; the count rate is unchanged.
  assign clear_count = power_src | fast_src | i_stop_req;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sys_cnt_reg <= '0;
    end else if (clear_count) begin
      sys_cnt_reg <= '0;
    end else begin
      sys_cnt_reg <= sys_cnt_reg + 13'h0001;
    end
  end
  assign o_sys_count = sys_cnt_reg;

  // Cause flags. A new reset episode clears old causes; causes arriving in the
  // same episode accumulate, but a power-up pulse leaves only the POR flag. The pin edge detector resets low, the idle level
  // of the inverted pin, so no false external cause follows reset.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ext_seen_reg <= 1'b0;
    end else begin
      ext_seen_reg <= ext_src;
    end
  end

  always_comb begin
    cause_next = cause_reg;
    if (power_src && i_power_up_pulse) begin
      cause_next = CAUSE_POR_VALUE;
    end else if (power_src || fast_src || (ext_src && !ext_seen_reg)) begin
      if (!o_internal_reset && state_reg != ST_EXT) begin
        cause_next = REG_RESET;
      end
      cause_next[CAUSE_LOW_BIT] = cause_next[CAUSE_LOW_BIT] | i_low_supply;
      cause_next[CAUSE_WDOG_BIT] = cause_next[CAUSE_WDOG_BIT] | i_watchdog_timeout;
      cause_next[CAUSE_OPC_BIT] = cause_next[CAUSE_OPC_BIT] | i_bad_opcode;
      cause_next[CAUSE_ADR_BIT] = cause_next[CAUSE_ADR_BIT] | i_bad_fetch_address;
      cause_next[CAUSE_MON_BIT] = cause_next[CAUSE_MON_BIT] | i_monitor_entry;
      cause_next[CAUSE_PIN_BIT] = cause_next[CAUSE_PIN_BIT] | ext_src;
    end
    cause_next[0] = 1'b0;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cause_reg <= CAUSE_POR_VALUE;
    end else begin
      cause_reg <= cause_next;
    end
  end

  // Software registers, one process each. Internal reset returns them to defaults.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bce_reg <= 1'b0;
    end else if (o_internal_reset) begin
      bce_reg <= 1'b0;
    end else if (wr_brk_ctrl) begin
      bce_reg <= i_wdata[BCE_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pll_sel_reg <= 1'b0;
    end else if (o_internal_reset) begin
      pll_sel_reg <= 1'b0;
    end else if (wr_clk_ctrl) begin
      pll_sel_reg <= i_wdata[PLL_SEL_BIT];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      short_stop_reg <= 1'b0;
    end else if (o_internal_reset) begin
      short_stop_reg <= 1'b0;
    end else if (wr_clk_ctrl) begin
      short_stop_reg <= i_wdata[SSR_BIT];
    end
  end
  assign o_break_clear_enable = bce_reg;

  // A break event in the same cycle as a clearing write keeps the flag set.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bsw_reg <= 1'b0;
    end else if (o_internal_reset) begin
      bsw_reg <= 1'b0;
    end else if (i_break_stop_wait) begin
      bsw_reg <= 1'b1;
    end else if (wr_brk_status && !i_wdata[BSW_BIT]) begin
      bsw_reg <= 1'b0;
    end
  end

  // Source flags are sampled each cycle; writes never touch them.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_reg <= 24'h000000;
    end else if (o_internal_reset) begin
      flags_reg <= 24'h000000;
    end else begin
      flags_reg <= {3'h0, i_source_flags[20:0]};
    end
  end

  // Read data are registered and fall back to zero when no read is pending, so
  // this port can be OR-ed with other read sources.
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (!i_rd) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= read_value(i_addr);
    end
  end
endmodule : system_clock_reset_control

// ===== bench/scrc_sva.sv
/*
  Concurrent checks on the ports of the system clock and reset control block.
  Assumes one clock domain and the asynchronous active-low reset i_rst_n.
*/
module scrc_sva (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_ext_reset_n,
  input wire logic i_monitor_mode,
  input wire logic i_stop_req,
  input wire logic [15:0] i_addr,
  input wire logic i_rd,
  input wire logic [7:0] o_rdata,
  input wire logic o_bus_clock,
  input wire logic o_cpu_clk_en,
  input wire logic o_periph_clk_en,
  input wire logic o_internal_reset,
  input wire logic o_reset_pin_out,
  input wire logic o_reset_pin_oe_n,
  input wire logic [15:0] o_reset_vector
);
  timeunit 1ns;
  timeprecision 1ns;
  import sys_ctl_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  AST_VECTOR: assert property (o_reset_vector == (i_monitor_mode ? VECTOR_MONITOR : VECTOR_USER))
    else $error("reset vector does not follow the mode input");
  AST_PIN_LOW: assert property (!o_reset_pin_oe_n |-> o_internal_reset && !o_reset_pin_out)
    else $error("reset pin driven outside internal reset");
  AST_CLK_HOLD: assert property (o_internal_reset |-> !o_cpu_clk_en && !o_periph_clk_en)
    else $error("clocks run during internal reset");
  AST_WAIT_CLK: assert property (o_cpu_clk_en |-> o_periph_clk_en)
    else $error("core clock runs without peripheral clock");
  AST_BUS_DIV: assert property ($rose(o_bus_clock) |=> o_bus_clock ##1 !o_bus_clock)
    else $error("bus clock high phase not two cycles");
  AST_TAIL: assert property ($rose(o_reset_pin_oe_n) |-> o_internal_reset[*8] ##[23:25] !o_internal_reset)
    else $error("internal reset tail not 32 cycles");
  AST_EXT_PIN: assert property (!i_ext_reset_n[*2] |-> o_internal_reset && o_reset_pin_oe_n)
    else $error("external reset handled wrongly");
  AST_CAUSE_B0: assert property (i_rd && i_addr == RST_CAUSE_ADDR |=> !o_rdata[0])
    else $error("cause bit 0 not zero");
  AST_FLAG_ZERO: assert property (i_rd && i_addr == FLAGS_HIGH_ADDR |=> !o_rdata[7])
    else $error("top source flag bit not zero");
  AST_STOP: assert property (i_stop_req && o_periph_clk_en |-> ##[1:2] !o_periph_clk_en)
    else $error("stop did not halt clocks");
endmodule : scrc_sva

bind system_clock_reset_control scrc_sva sva_inst (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
  .i_ext_reset_n(i_ext_reset_n), .i_monitor_mode(i_monitor_mode), .i_stop_req(i_stop_req), .i_addr(i_addr),
  .i_rd(i_rd), .o_rdata(o_rdata), .o_bus_clock(o_bus_clock), .o_cpu_clk_en(o_cpu_clk_en),
  .o_periph_clk_en(o_periph_clk_en), .o_internal_reset(o_internal_reset), .o_reset_pin_out(o_reset_pin_out),
  .o_reset_pin_oe_n(o_reset_pin_oe_n), .o_reset_vector(o_reset_vector));

// ===== bench/core_model.sv
/*
  Clock source model standing beside the core: it makes the divided PLL clock.
  Assumes the reference clock is the only timing source of the bench.
*/
module core_model (
  input wire logic i_ref_clk,
  output logic o_pll_clk
);
  timeunit 1ns;
  timeprecision 1ns;
  // Half the reference rate, so a selected PLL path differs visibly from ref/2 phase.
  initial o_pll_clk = 1'b1;
  always @(posedge i_ref_clk) o_pll_clk <= ~o_pll_clk;
endmodule : core_model

// ===== bench/test_system_clock_reset_control.sv
/*
  Self-checking bench for the system clock and reset control block.
  Assumes the checker is bound to the design and the core model makes the PLL clock.
*/
module test_system_clock_reset_control;
  timeunit 1ns;
  timeprecision 1ns;
  import sys_ctl_pkg::*;
  localparam int STAB = 64;
  localparam logic [20:0] F = 21'h15A5A5;
  localparam int CB [5] = '{CAUSE_WDOG_BIT, CAUSE_LOW_BIT, CAUSE_OPC_BIT, CAUSE_ADR_BIT, CAUSE_MON_BIT};
  logic clk = 1'b0, rst_n = 1'b0, pwr = 1'b0, ext_n = 1'b1, mon = 1'b0, stp = 1'b0, wt = 1'b0;
  logic wake = 1'b0, brk = 1'b0, wr = 1'b0, rd = 1'b0, pll, cgo, busclk, cpu_en, per_en, internal_reset_signal, pin, oe_n, bce;
  logic [4:0] src = 5'h00;
  logic [20:0] flags = 21'h000000;
  logic [15:0] addr = 16'h0000, vec;
  logic [7:0] wdata = 8'h00, rdata, c;
  logic [12:0] cnt, c0;
  int err_total = 0, compares = 0, n;
  always #20 clk = ~clk;
  core_model core_model_inst (.i_ref_clk(clk), .o_pll_clk(pll));
  system_clock_reset_control #(.STAB_COUNT(STAB), .FLAG_COUNT(21)) system_clock_reset_control_inst (
    .i_ref_clk(clk), .i_rst_n(rst_n), .i_pll_clk(pll), .i_power_up_pulse(pwr), .i_ext_reset_n(ext_n),
    .i_watchdog_timeout(src[0]), .i_low_supply(src[1]), .i_bad_opcode(src[2]), .i_bad_fetch_address(src[3]),
    .i_monitor_entry(src[4]), .i_monitor_mode(mon), .i_stop_req(stp), .i_wait_req(wt), .i_wake(wake),
    .i_break_stop_wait(brk), .i_source_flags(flags), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_clock_gen_output(cgo), .o_bus_clock(busclk), .o_cpu_clk_en(cpu_en),
    .o_periph_clk_en(per_en), .o_internal_reset(internal_reset_signal), .o_reset_pin_out(pin), .o_reset_pin_oe_n(oe_n),
    .o_reset_vector(vec), .o_sys_count(cnt), .o_break_clear_enable(bce));
  task automatic print_verdict();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (compares > 0 && err_total == 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : print_verdict
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wrr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdc(input logic [15:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk({8'h00, rdata}, {8'h00, e});
  endtask : rdc
  task automatic wait_run(input int lo, input int hi);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (!(per_en === 1'b1 && internal_reset_signal === 1'b0) && n < 9000);
    chk(16'(n >= lo && n <= hi), 16'h0001);
  endtask : wait_run
  task automatic pulse_on(input int which);
    @(posedge clk);
    {brk, wake, wt, stp} <= 4'(1 << which);
    @(posedge clk);
    {brk, wake, wt, stp} <= 4'h0;
    repeat (3) @(posedge clk);
  endtask : pulse_on
  initial begin
    #800000;
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    wait_run(STAB + 63, STAB + 67);
    rdc(RST_CAUSE_ADDR, CAUSE_POR_VALUE);
    rdc(BRK_STATUS_ADDR, REG_RESET);
    rdc(BRK_CTRL_ADDR, REG_RESET);
    rdc(FLAGS_LOW_ADDR, REG_RESET);
    $display("test reset finished");
    @(posedge clk);
    flags <= F;
    wrr(RST_CAUSE_ADDR, 8'hFF);
    rdc(RST_CAUSE_ADDR, CAUSE_POR_VALUE);
    wrr(FLAGS_LOW_ADDR, 8'h00);
    rdc(FLAGS_LOW_ADDR, {F[5:0], 2'b00});
    rdc(FLAGS_MID_ADDR, F[13:6]);
    rdc(FLAGS_HIGH_ADDR, {1'b0, F[20:14]});
    rdc(16'hFE03, 8'h00);
    wrr(BRK_CTRL_ADDR, 8'hFF);
    rdc(BRK_CTRL_ADDR, 8'h80);
    chk({15'h0000, bce}, 16'h0001);
    pulse_on(3);
    wrr(BRK_STATUS_ADDR, 8'hFF);
    rdc(BRK_STATUS_ADDR, 8'h02);
    wrr(BRK_STATUS_ADDR, 8'h00);
    rdc(BRK_STATUS_ADDR, 8'h00);
    $display("test registers finished");
    pulse_on(1);
    chk({14'h0000, cpu_en, per_en}, 16'h0001);
    pulse_on(2);
    chk({14'h0000, cpu_en, per_en}, 16'h0003);
    wrr(CLK_CTRL_ADDR, 8'h01);
    repeat (3) begin
      @(negedge clk);
      chk({15'h0000, cgo}, {15'h0000, pll});
    end
    wrr(CLK_CTRL_ADDR, 8'h02);
    @(negedge clk);
    c = {7'h00, cgo};
    @(negedge clk);
    chk({15'h0000, cgo}, {15'h0000, ~c[0]});
    pulse_on(0);
    chk({15'h0000, per_en}, 16'h0000);
    pulse_on(2);
    wait_run(27, 36);
    wrr(CLK_CTRL_ADDR, 8'h00);
    pulse_on(0);
    pulse_on(2);
    wait_run(STAB - 5, 4100);
    chk(16'(n >= STAB - 5 && n <= STAB + 4 || n >= 4091), 16'h0001);
    $display("test clocks finished");
    for (int i = 0; i < 5; i++) begin
      @(posedge clk);
      src <= 5'(1 << i);
      mon <= i[0];
      @(posedge clk);
      src <= 5'h00;
      wait_run((i == 1 ? STAB : 0) + 62, (i == 1 ? STAB : 0) + 67);
      chk(16'(cnt < 13'd200), 16'h0001);
      chk(vec, i[0] ? VECTOR_MONITOR : VECTOR_USER);
      rdc(RST_CAUSE_ADDR, 8'(1 << CB[i]));
      rdc(BRK_CTRL_ADDR, 8'h00);
    end
    c0 = cnt;
    @(posedge clk);
    ext_n <= 1'b0;
    repeat (70) @(posedge clk);
    @(negedge clk);
    chk({14'h0000, internal_reset_signal, oe_n}, 16'h0003);
    @(posedge clk);
    ext_n <= 1'b1;
    wait_run(1, 100);
    chk(16'(cnt > c0), 16'h0001);
    rdc(RST_CAUSE_ADDR, 8'h40);
    $display("test resets finished");
    print_verdict();
  end
endmodule : test_system_clock_reset_control
